/* File: rtl/cpie_pkg.sv */
// Package: register map, field layout, reset values and bus states of the copper interrupt block
package cpie_pkg;

  // Bus geometry: byte address, word index in bits 6:2, port bank in bits 8:7
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FLAG_W = 16;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned BANK_LSB = 7;
  localparam int unsigned BANK_W = 2;
  localparam int unsigned MAX_PORTS = 4;

  // Register indices; byte address is bank * 0x80 + index * 4
  localparam logic [4:0] IDX_MASK = 5'h12;
  localparam logic [4:0] IDX_FLAGS = 5'h13;
  localparam logic [4:0] IDX_SUMMARY = 5'h17;
  localparam logic [4:0] IDX_IRQ_STATUS = 5'h1C;
  localparam logic [4:0] IDX_IRQ_ENABLE = 5'h1D;
  localparam logic [4:0] IDX_IRQ_CLEAR = 5'h1E;

  // Values after reset, and the mask of implemented flag bits
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] FLAGS_VALID = 16'hFF7F;
  localparam logic [3:0] IRQ_ST_RST = 4'h0;
  localparam logic [3:0] IRQ_EN_RST = 4'h0;
  localparam logic [7:0] LSTATE_RST = 8'h00;

  // Flag bit positions
  localparam int unsigned BIT_AN_ERR = 15;
  localparam int unsigned BIT_SPEED = 14;
  localparam int unsigned BIT_DUPLEX = 13;
  localparam int unsigned BIT_PAGE = 12;
  localparam int unsigned BIT_AN_DONE = 11;
  localparam int unsigned BIT_LINK = 10;
  localparam int unsigned BIT_SYMBOL = 9;
  localparam int unsigned BIT_FALSE_CAR = 8;
  localparam int unsigned BIT_RSVD = 7;
  localparam int unsigned BIT_MDIX = 6;
  localparam int unsigned BIT_DOWNSHIFT = 5;
  localparam int unsigned BIT_CABLE = 4;
  localparam int unsigned BIT_FLP_NOLINK = 3;
  localparam int unsigned BIT_DTE = 2;
  localparam int unsigned BIT_POLARITY = 1;
  localparam int unsigned BIT_JABBER = 0;

  // Packed link state: speed 7:6, duplex 5, link 4, mdix 3, cable 2, dte 1, polarity 0
  localparam int unsigned LST_W = 8;
  localparam int unsigned LST_SPEED = 6;
  localparam int unsigned LST_DUPLEX = 5;
  localparam int unsigned LST_LINK = 4;
  localparam int unsigned LST_MDIX = 3;
  localparam int unsigned LST_CABLE = 2;
  localparam int unsigned LST_DTE = 1;
  localparam int unsigned LST_POL = 0;

  typedef enum logic [0:0] {
    CPIE_BUS_IDLE,
    CPIE_BUS_ANSWER
  } cpie_bus_state_t;

endpackage : cpie_pkg

/* File: rtl/cpie_flag_latch.sv */
// Latched-high flag register of one port, cleared by a read of the bits it returned
`timescale 1ns/1ps
module cpie_flag_latch #(
  parameter int unsigned WIDTH = 16,
  parameter logic [WIDTH-1:0] VALID = cpie_pkg::FLAGS_VALID,
  parameter logic [WIDTH-1:0] RST = cpie_pkg::FLAGS_RST
) (
  input wire logic clk_i,                      // Core clock
  input wire logic sys_rst_i,                  // Hardware reset, sync, high
  input wire logic soft_rst_i,                 // Software reset pulse
  input wire logic [WIDTH-1:0] event_i,        // Event present this cycle
  input wire logic clear_i,                    // Read of the flags taken
  input wire logic [WIDTH-1:0] clear_mask_i,   // Bits that read returned
  output logic [WIDTH-1:0] flags_o             // Latched flags
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;
  logic [WIDTH-1:0] clr;

  // Only the bits the host actually saw are cleared, so an event after the snapshot survives
  always_comb begin
    clr = clear_i ? clear_mask_i : '0;
    if (soft_rst_i) begin
      flags_next = RST;                                    // R15
    end else begin
      flags_next = ((flags_reg & ~clr) | event_i) & VALID; // R16
    end
  end

  // Flag storage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flags_reg <= RST;                                    // R15
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags_o = flags_reg;

endmodule : cpie_flag_latch

/* File: rtl/cpie_irq_agg.sv */
// Block interrupt: sticky per-port status, enable, write-one-clear and one level output
`timescale 1ns/1ps
module cpie_irq_agg #(
  parameter int unsigned NUM_SRC = 4
) (
  input wire logic clk_i,                      // Core clock
  input wire logic sys_rst_i,                  // Hardware reset, sync, high
  input wire logic [NUM_SRC-1:0] src_i,        // Port interrupt levels
  input wire logic en_we_i,                    // Enable register write
  input wire logic [NUM_SRC-1:0] en_wdata_i,   // Enable write data
  input wire logic clr_we_i,                   // Clear register write
  input wire logic [NUM_SRC-1:0] clr_wdata_i,  // Ones clear status bits
  output logic [NUM_SRC-1:0] status_o,         // Sticky status
  output logic [NUM_SRC-1:0] enable_o,         // Enable register
  output logic irq_o                           // Level interrupt, registered
);

  logic [NUM_SRC-1:0] prev_reg, prev_next;
  logic [NUM_SRC-1:0] st_reg, st_next;
  logic [NUM_SRC-1:0] en_reg, en_next;
  logic irq_reg, irq_next;

  // A rising port interrupt sets status; set wins over a clear in the same cycle
  always_comb begin
    prev_next = src_i;
    st_next = (st_reg & ~(clr_we_i ? clr_wdata_i : '0)) | (src_i & ~prev_reg);
    en_next = en_we_i ? en_wdata_i : en_reg;
    irq_next = |(st_next & en_next);
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prev_reg <= '0;
      st_reg <= NUM_SRC'(cpie_pkg::IRQ_ST_RST);
      en_reg <= NUM_SRC'(cpie_pkg::IRQ_EN_RST);
      irq_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      st_reg <= st_next;
      en_reg <= en_next;
      irq_reg <= irq_next;
    end
  end

  assign status_o = st_reg;
  assign enable_o = en_reg;
  assign irq_o = irq_reg;

endmodule : cpie_irq_agg

/* File: rtl/cpie_top.sv */
// Copper port interrupt enable and status registers with an Avalon-MM slave
//
// Notes on behaviour
// R1: Enable register, 16 bits R/W, 1 enables event; cleared by hardware reset only.
// R2: Flag bit 15 latches on any auto-negotiation error.
// R3: Flag bit 14 latches when resolved speed changes; zero otherwise.
// R4: Flag bit 13 latches when resolved duplex changes; zero otherwise.
// R5: Flag bit 12 latches when a new negotiation page arrives.
// R6: Flag bit 11 latches when negotiation completes; zero before.
// R7: Flag bit 10 latches when link goes up or down.
// R8: Flag bit 9 latches on symbol error, bit 8 on false carrier.
// R9: Flag bit 6 latches when MDI/MDIX crossover state changes.
// R10: Flag bit 5 latches when a speed downshift is detected.
// R11: Flag bit 4 latches when cable detect toggles sleep and active.
// R12: Flag bit 3 latches when pulse exchange ends without link.
// R13: Flag bit 2 latches when partner DTE power status changes.
// R14: Flag bit 1 latches when receive polarity changes.
// R15: Bit 0 latches jabber; bit 7 reads zero; both resets clear flags.
// R16: Flags hold until read; read clears unless event still present.
// R17: Port interrupt high while any flag and its enable bit are set.
// R18: Read-only summary holds one active-interrupt bit per port in bits 3:0.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module cpie_top #(
  parameter int unsigned NUM_PORTS = 4
) (
  input wire logic clk_i,                           // Core clock, 25 MHz
  input wire logic sys_rst_i,                       // Hardware reset, sync, high
  input wire logic soft_rst_i,                      // Software reset pulse
  // Avalon-MM slave
  input wire logic [8:0] avs_address_i,             // Byte address
  input wire logic avs_read_i,                      // Read request
  input wire logic avs_write_i,                     // Write request
  input wire logic [3:0] avs_byteenable_i,          // Byte lanes
  input wire logic [31:0] avs_writedata_i,          // Write data
  output logic [31:0] avs_readdata_o,               // Read data, registered
  output logic avs_waitrequest_o,                   // Stall until answer
  // Per-port link state levels, same clock domain
  input wire logic [2*NUM_PORTS-1:0] speed_i,       // Resolved speed code
  input wire logic [NUM_PORTS-1:0] duplex_i,        // Resolved duplex
  input wire logic [NUM_PORTS-1:0] link_i,          // Link up
  input wire logic [NUM_PORTS-1:0] mdix_i,          // Crossover state
  input wire logic [NUM_PORTS-1:0] cable_sleep_i,   // Cable detect sleep
  input wire logic [NUM_PORTS-1:0] dte_power_i,     // Partner needs power
  input wire logic [NUM_PORTS-1:0] polarity_i,      // Receive reversed
  // Per-port event indications, pulse or level
  input wire logic [NUM_PORTS-1:0] an_error_i,      // Negotiation error
  input wire logic [NUM_PORTS-1:0] page_rx_i,       // Page received
  input wire logic [NUM_PORTS-1:0] an_done_i,       // Negotiation completed
  input wire logic [NUM_PORTS-1:0] symbol_err_i,    // Symbol error
  input wire logic [NUM_PORTS-1:0] false_carrier_i, // False carrier
  input wire logic [NUM_PORTS-1:0] downshift_i,     // Downshift detected
  input wire logic [NUM_PORTS-1:0] flp_no_link_i,   // Pulse exchange, no link
  input wire logic [NUM_PORTS-1:0] jabber_i,        // Jabber
  // Interrupts
  output logic [NUM_PORTS-1:0] port_irq_o,          // Per-port interrupt level
  output logic irq_o                                // Block interrupt level
);

  localparam int unsigned FW = cpie_pkg::FLAG_W;
  localparam int unsigned LW = cpie_pkg::LST_W;
  localparam int unsigned BW = cpie_pkg::BANK_W;

  // Summary and bank decode only serve up to four ports
  if (NUM_PORTS < 1 || NUM_PORTS > cpie_pkg::MAX_PORTS) begin : g_bad_ports
    $error("NUM_PORTS must be 1 to 4");
  end

  // ------------------------------------------------------------------
  // Bus handshake: every request waits exactly one cycle
  // ------------------------------------------------------------------
  cpie_pkg::cpie_bus_state_t bus_state_reg, bus_state_next;
  logic req;
  logic take;
  logic take_rd;
  logic take_wr;
  logic [cpie_pkg::IDX_W-1:0] idx;
  logic [BW-1:0] bank;

  assign req = avs_read_i | avs_write_i;
  assign idx = avs_address_i[cpie_pkg::IDX_LSB +: cpie_pkg::IDX_W];
  assign bank = avs_address_i[cpie_pkg::BANK_LSB +: BW];

  // Request is taken at the edge that ends the answer cycle
  assign take = (bus_state_reg == cpie_pkg::CPIE_BUS_ANSWER);
  assign take_rd = take & avs_read_i;
  assign take_wr = take & avs_write_i;

  // Waitrequest is combinational so the first request cycle always stalls
  assign avs_waitrequest_o = req & ~take;

  // Next state of the handshake
  always_comb begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      cpie_pkg::CPIE_BUS_IDLE: begin
        if (req) begin
          bus_state_next = cpie_pkg::CPIE_BUS_ANSWER;
        end
      end
      cpie_pkg::CPIE_BUS_ANSWER: begin
        bus_state_next = cpie_pkg::CPIE_BUS_IDLE;
      end
      default: begin
        bus_state_next = cpie_pkg::CPIE_BUS_IDLE;
      end
    endcase
  end

  // Handshake state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bus_state_reg <= cpie_pkg::CPIE_BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  // ------------------------------------------------------------------
  // Per-port logic
  // ------------------------------------------------------------------
  logic [NUM_PORTS*FW-1:0] mask_all;
  logic [NUM_PORTS*FW-1:0] flags_all;
  logic [NUM_PORTS-1:0] port_irq;
  logic [31:0] rdata_reg, rdata_next;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [LW-1:0] lstate;
    logic [LW-1:0] prev_reg, prev_next;
    logic primed_reg, primed_next;
    logic [LW-1:0] changed;
    logic [FW-1:0] events;
    logic [FW-1:0] mask_reg, mask_next;
    logic [FW-1:0] flags;
    logic sel;
    logic mask_we;
    logic flags_rd;

    // Gather the link state that is watched for changes
    assign lstate = {speed_i[2*p +: 2], duplex_i[p], link_i[p], mdix_i[p],
                     cable_sleep_i[p], dte_power_i[p], polarity_i[p]};

    // No change is reported until one sample follows reset, avoiding a false first event
    always_comb begin
      prev_next = lstate;
      primed_next = 1'b1;
      changed = primed_reg ? (lstate ^ prev_reg) : '0;
    end

    // Previous link state
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        prev_reg <= cpie_pkg::LSTATE_RST;
        primed_reg <= 1'b0;
      end else begin
        prev_reg <= prev_next;
        primed_reg <= primed_next;
      end
    end

    // Map each source onto its flag position
    always_comb begin
      events = '0;
      events[cpie_pkg::BIT_AN_ERR] = an_error_i[p];                            // R2
      events[cpie_pkg::BIT_SPEED] = |changed[cpie_pkg::LST_SPEED +: 2];        // R3
      events[cpie_pkg::BIT_DUPLEX] = changed[cpie_pkg::LST_DUPLEX];            // R4
      events[cpie_pkg::BIT_PAGE] = page_rx_i[p];                               // R5
      events[cpie_pkg::BIT_AN_DONE] = an_done_i[p];                            // R6
      events[cpie_pkg::BIT_LINK] = changed[cpie_pkg::LST_LINK];                // R7
      events[cpie_pkg::BIT_SYMBOL] = symbol_err_i[p];                          // R8
      events[cpie_pkg::BIT_FALSE_CAR] = false_carrier_i[p];                    // R8
      events[cpie_pkg::BIT_RSVD] = 1'b0;                                       // R15
      events[cpie_pkg::BIT_MDIX] = changed[cpie_pkg::LST_MDIX];                // R9
      events[cpie_pkg::BIT_DOWNSHIFT] = downshift_i[p];                        // R10
      events[cpie_pkg::BIT_CABLE] = changed[cpie_pkg::LST_CABLE];              // R11
      events[cpie_pkg::BIT_FLP_NOLINK] = flp_no_link_i[p];                     // R12
      events[cpie_pkg::BIT_DTE] = changed[cpie_pkg::LST_DTE];                  // R13
      events[cpie_pkg::BIT_POLARITY] = changed[cpie_pkg::LST_POL];             // R14
      events[cpie_pkg::BIT_JABBER] = jabber_i[p];                              // R15
    end

    // Address decode for this port's bank
    assign sel = (bank == BW'(p));
    assign mask_we = take_wr & sel & (idx == cpie_pkg::IDX_MASK);
    assign flags_rd = take_rd & sel & (idx == cpie_pkg::IDX_FLAGS);

    // Enable register honours byte lanes 0 and 1; software reset leaves it alone
    always_comb begin
      mask_next = mask_reg;
      if (mask_we && avs_byteenable_i[0]) begin
        mask_next[7:0] = avs_writedata_i[7:0];                                 // R1
      end
      if (mask_we && avs_byteenable_i[1]) begin
        mask_next[15:8] = avs_writedata_i[15:8];                               // R1
      end
    end

    // Enable register storage
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        mask_reg <= cpie_pkg::MASK_RST;                                        // R1
      end else begin
        mask_reg <= mask_next;
      end
    end

    // Flags clear with the snapshot held in the read data register
    cpie_flag_latch #(
      .WIDTH(FW),
      .VALID(cpie_pkg::FLAGS_VALID),
      .RST(cpie_pkg::FLAGS_RST)
    ) u_flags (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .soft_rst_i(soft_rst_i),
      .event_i(events),
      .clear_i(flags_rd),
      .clear_mask_i(rdata_reg[FW-1:0]),
      .flags_o(flags)
    );

    // Port interrupt follows flags and enables directly
    assign port_irq[p] = |(flags & mask_reg);                                  // R17
    assign mask_all[p*FW +: FW] = mask_reg;
    assign flags_all[p*FW +: FW] = flags;
  end

  assign port_irq_o = port_irq;

  // ------------------------------------------------------------------
  // Block interrupt over the port interrupts
  // ------------------------------------------------------------------
  logic [NUM_PORTS-1:0] irq_status;
  logic [NUM_PORTS-1:0] irq_enable;
  logic irq_en_we;
  logic irq_clr_we;

  // These registers answer in every bank
  assign irq_en_we = take_wr & avs_byteenable_i[0] & (idx == cpie_pkg::IDX_IRQ_ENABLE);
  assign irq_clr_we = take_wr & avs_byteenable_i[0] & (idx == cpie_pkg::IDX_IRQ_CLEAR);

  cpie_irq_agg #(
    .NUM_SRC(NUM_PORTS)
  ) u_irq (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .src_i(port_irq),
    .en_we_i(irq_en_we),
    .en_wdata_i(avs_writedata_i[NUM_PORTS-1:0]),
    .clr_we_i(irq_clr_we),
    .clr_wdata_i(avs_writedata_i[NUM_PORTS-1:0]),
    .status_o(irq_status),
    .enable_o(irq_enable),
    .irq_o(irq_o)
  );

  // ------------------------------------------------------------------
  // Read data: captured when a read is first seen, held through the answer
  // ------------------------------------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    if (bus_state_reg == cpie_pkg::CPIE_BUS_IDLE && avs_read_i) begin
      rdata_next = 32'h0000_0000;
      case (idx)
        cpie_pkg::IDX_MASK: begin
          for (int i = 0; i < NUM_PORTS; i++) begin
            if (bank == BW'(i)) begin
              rdata_next[FW-1:0] = mask_all[i*FW +: FW];                       // R1
            end
          end
        end
        cpie_pkg::IDX_FLAGS: begin
          for (int i = 0; i < NUM_PORTS; i++) begin
            if (bank == BW'(i)) begin
              rdata_next[FW-1:0] = flags_all[i*FW +: FW];                      // R16
            end
          end
        end
        cpie_pkg::IDX_SUMMARY: begin
          rdata_next[NUM_PORTS-1:0] = port_irq;                                // R18
        end
        cpie_pkg::IDX_IRQ_STATUS: begin
          rdata_next[NUM_PORTS-1:0] = irq_status;
        end
        cpie_pkg::IDX_IRQ_ENABLE: begin
          rdata_next[NUM_PORTS-1:0] = irq_enable;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata_o = rdata_reg;

endmodule : cpie_top

/* File: tb/cpie_top_checker.sv */
// Port-level assertions for the copper interrupt block
`timescale 1ns/1ps
module cpie_top_checker #(
  parameter int unsigned NUM_PORTS = 4
) (
  input wire logic clk_i,                      // Core clock
  input wire logic sys_rst_i,                  // Hardware reset
  input wire logic soft_rst_i,                 // Software reset
  input wire logic [8:0] avs_address_i,        // Byte address
  input wire logic avs_read_i,                 // Read request
  input wire logic avs_write_i,                // Write request
  input wire logic [31:0] avs_readdata_o,      // Read data
  input wire logic avs_waitrequest_o,          // Stall
  input wire logic [NUM_PORTS-1:0] port_irq_o, // Port interrupts
  input wire logic irq_o                       // Block interrupt
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // A read is taken at an edge where the stall is low
  logic rd_take;
  logic no_req;
  assign rd_take = avs_read_i && !avs_waitrequest_o;
  assign no_req = !avs_read_i && !avs_write_i;
  AST_IDLE_NOWAIT: assert property (no_req |-> !avs_waitrequest_o)
    else $error("stall raised with no request");
  AST_ONE_WAIT: assert property ($rose(avs_read_i || avs_write_i) |->
    avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("request not answered after exactly one wait cycle");
  AST_RESET_QUIET: assert property ($fell(sys_rst_i) |->
    port_irq_o == '0 && !irq_o && avs_readdata_o == 32'h0)
    else $error("outputs not cleared by hardware reset");
  AST_SOFT_CLEAR: assert property (soft_rst_i |=> port_irq_o == '0)
    else $error("port interrupt survived software reset");
  AST_SUMMARY: assert property (rd_take && avs_address_i[6:2] == cpie_pkg::IDX_SUMMARY
    |-> avs_readdata_o == 32'($past(port_irq_o)))
    else $error("summary read differs from port interrupts");
  AST_RSVD_BIT7: assert property (rd_take && avs_address_i[6:2] == cpie_pkg::IDX_FLAGS
    |-> !avs_readdata_o[7])
    else $error("reserved flag bit read as one");
  AST_UPPER_ZERO: assert property (rd_take |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("read data above bit 15 not zero");
  // Latched flags cannot drop without a read, a write or a reset
  AST_STICKY: assert property (no_req && !soft_rst_i |=>
    (port_irq_o & $past(port_irq_o)) == $past(port_irq_o))
    else $error("port interrupt dropped without a read");
  AST_BLOCK_CAUSE: assert property ($rose(irq_o) |->
    $past(|port_irq_o) || $past(avs_write_i))
    else $error("block interrupt rose without a cause");
  COV_FLAG_READ: cover property (rd_take && avs_address_i[6:2] == cpie_pkg::IDX_FLAGS
    && avs_readdata_o != 32'h0);
  COV_IRQ: cover property ($rose(irq_o));
  COV_SOFT: cover property (soft_rst_i && port_irq_o != '0);
endmodule : cpie_top_checker

bind cpie_top cpie_top_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .port_irq_o(port_irq_o), .irq_o(irq_o));

/* File: tb/cpie_host_model.sv */
// Management host model: Avalon-MM master that waits out the stall
`timescale 1ns/1ps
module cpie_host_model (
  input wire logic clk_i,                 // Core clock
  input wire logic [31:0] avs_readdata_i, // Read data from slave
  input wire logic avs_waitrequest_i,     // Slave stall
  output logic [8:0] avs_address_o,       // Byte address
  output logic avs_read_o,                // Read request
  output logic avs_write_o,               // Write request
  output logic [3:0] avs_byteenable_o,    // Byte lanes
  output logic [31:0] avs_writedata_o     // Write data
);
  initial begin
    avs_address_o = 9'h000;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_byteenable_o = 4'hF;
    avs_writedata_o = 32'h0;
  end
  // Stall and read data are looked at in the edge's own time step, before it updates them
  task access(input logic wr, input logic [8:0] adr, input logic [31:0] wd,
              output logic [31:0] rdat);
    @(posedge clk_i);
    avs_read_o <= !wr;
    avs_write_o <= wr;
    avs_address_o <= adr;
    avs_writedata_o <= wd;
    do @(posedge clk_i); while (avs_waitrequest_i !== 1'b0);
    rdat = avs_readdata_i;
    // Released lines show garbage, not the last value
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    avs_address_o <= ~adr;
    avs_writedata_o <= ~wd;
  endtask : access
endmodule : cpie_host_model

/* File: tb/cpie_top_test.sv */
// Self-checking bench for the copper interrupt block
`timescale 1ns/1ps
module cpie_top_test;
  logic clk_i;
  logic sys_rst_i;
  logic soft_rst_i;
  logic [8:0] adr;
  logic rdv;
  logic wrv;
  logic [3:0] be;
  logic [31:0] wd;
  logic [31:0] rdata;
  logic wreq;
  logic [7:0] spd;
  logic [3:0] lv [6];
  logic [3:0] ev [8];
  logic [3:0] port_irq;
  logic irq;
  logic [15:0] seed;
  logic [31:0] q;
  int n_mismatch;
  int n_compared;
  int cyc;
  int exp_mask [4];
  // Flag positions of the pulse events and of the level changes
  int pb [8] = '{15, 12, 11, 9, 8, 5, 3, 0};
  int lb [6] = '{13, 10, 6, 4, 2, 1};

  cpie_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i),
    .avs_address_i(adr), .avs_read_i(rdv), .avs_write_i(wrv), .avs_byteenable_i(be),
    .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .speed_i(spd), .duplex_i(lv[0]), .link_i(lv[1]), .mdix_i(lv[2]),
    .cable_sleep_i(lv[3]), .dte_power_i(lv[4]), .polarity_i(lv[5]),
    .an_error_i(ev[0]), .page_rx_i(ev[1]), .an_done_i(ev[2]), .symbol_err_i(ev[3]),
    .false_carrier_i(ev[4]), .downshift_i(ev[5]), .flp_no_link_i(ev[6]),
    .jabber_i(ev[7]), .port_irq_o(port_irq), .irq_o(irq));
  cpie_host_model host (.clk_i(clk_i), .avs_readdata_i(rdata), .avs_waitrequest_i(wreq),
    .avs_address_o(adr), .avs_read_o(rdv), .avs_write_o(wrv), .avs_byteenable_o(be),
    .avs_writedata_o(wd));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One bus cycle; the model mirrors every port enable register write
  task acc(input logic wr, input logic [1:0] b, input logic [4:0] ix, input logic [31:0] d);
    host.access(wr, {b, ix, 2'b00}, d, q);
    if (wr && ix == cpie_pkg::IDX_MASK) exp_mask[b] = int'(d[15:0]);
  endtask : acc
  task pulse(input int i, input int p);
    @(posedge clk_i);
    ev[i][p] <= 1'b1;
    @(posedge clk_i);
    ev[i][p] <= 1'b0;
    @(negedge clk_i);
  endtask : pulse
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // A hang is cut short well beyond the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    sys_rst_i = 1'b1;
    soft_rst_i = 1'b0;
    spd = 8'h00;
    for (int i = 0; i < 8; i++) ev[i] = 4'h0;
    for (int i = 0; i < 6; i++) lv[i] = 4'h0;
    exp_mask = '{default: 0};
    seed = 16'h7740;
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    // Reset values, then random enables with junk in the upper half
    for (int b = 0; b < 4; b++) begin
      acc(0, 2'(b), cpie_pkg::IDX_FLAGS, 32'h0);
      chk("flags at reset", q, 32'h0);
      seed = lfsr(seed);
      acc(1, 2'(b), cpie_pkg::IDX_MASK, {seed, seed});
      acc(0, 2'(b), cpie_pkg::IDX_MASK, 32'h0);
      chk("enable readback", q, exp_mask[b]);
    end
    acc(1, 2'h0, cpie_pkg::IDX_MASK, 32'h0000FFFF);
    acc(1, 2'h0, cpie_pkg::IDX_IRQ_ENABLE, 32'h0000000F);
    // Every pulse event: latch, interrupt, read-clear
    for (int i = 0; i < 8; i++) begin
      pulse(i, 0);
      chk("port irq set", 32'(port_irq[0]), 32'h1);
      acc(0, 2'h0, cpie_pkg::IDX_FLAGS, 32'h0);
      chk("event flag", q, 32'h1 << pb[i]);
      acc(0, 2'h0, cpie_pkg::IDX_FLAGS, 32'h0);
      @(negedge clk_i);
      chk("flag after read", q, 32'h0);
      chk("port irq cleared", 32'(port_irq[0]), 32'h0);
    end
    chk("block irq", 32'(irq), 32'h1);
    acc(0, 2'h3, cpie_pkg::IDX_IRQ_STATUS, 32'h0);
    chk("block status", q, 32'h1);
    acc(1, 2'h0, cpie_pkg::IDX_IRQ_CLEAR, 32'h0000000F);
    repeat (2) @(negedge clk_i);
    chk("block irq cleared", 32'(irq), 32'h0);
    acc(0, 2'h1, cpie_pkg::IDX_IRQ_ENABLE, 32'h0);
    chk("block enable", q, 32'hF);
    // Masked event still latches but raises nothing
    acc(1, 2'h0, cpie_pkg::IDX_MASK, 32'h0);
    pulse(7, 0);
    chk("masked irq", 32'(port_irq[0]), 32'h0);
    acc(0, 2'h0, cpie_pkg::IDX_FLAGS, 32'h0);
    chk("masked flag", q, 32'h1);
    // Level changes, speed code last
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_i);
      if (i < 6) lv[i][0] <= ~lv[i][0];
      else spd[1:0] <= 2'h2;
      @(posedge clk_i);
      acc(0, 2'h0, cpie_pkg::IDX_FLAGS, 32'h0);
      chk("change flag", q, 32'h1 << (i < 6 ? lb[i] : 14));
    end
    // Software reset clears flags, keeps enables
    acc(1, 2'h0, cpie_pkg::IDX_MASK, 32'h0000FFFF);
    pulse(7, 0);
    @(posedge clk_i);
    soft_rst_i <= 1'b1;
    @(posedge clk_i);
    soft_rst_i <= 1'b0;
    acc(0, 2'h0, cpie_pkg::IDX_FLAGS, 32'h0);
    chk("flags after soft reset", q, 32'h0);
    acc(0, 2'h0, cpie_pkg::IDX_MASK, 32'h0);
    chk("enable kept", q, exp_mask[0]);
    // Summary shows the port with a live interrupt
    acc(1, 2'h2, cpie_pkg::IDX_MASK, 32'h0000FFFF);
    pulse(7, 2);
    acc(0, 2'h1, cpie_pkg::IDX_SUMMARY, 32'h0);
    chk("summary", q, 32'h4);
    acc(1, 2'h0, 5'h00, 32'hFFFFFFFF);
    acc(0, 2'h0, 5'h00, 32'h0);
    chk("unmapped", q, 32'h0);
    // Hardware reset in mid-run clears enables
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    exp_mask = '{default: 0};
    @(posedge clk_i);
    acc(0, 2'h2, cpie_pkg::IDX_MASK, 32'h0);
    chk("enable after reset", q, exp_mask[2]);
    summarize();
  end
endmodule : cpie_top_test
